// ---- src/acd_pkg.sv ----
/*
 Package for the ATA command decoder: register offsets, field layouts,
 opcodes, identify words, state enumeration and bus carrier structs.
 Assumes a single 10 MHz clock domain and an AHB-Lite register bus.
*/
package acd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_SCNT = 8'h04;
  localparam logic [7:0] OFF_SNUM = 8'h08;
  localparam logic [7:0] OFF_CYL = 8'h0C;
  localparam logic [7:0] OFF_DRVHD = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_ALTST = 8'h1C;
  localparam logic [7:0] OFF_DEVCTL = 8'h20;
  localparam logic [7:0] OFF_DATA = 8'h24;
  localparam logic [7:0] OFF_ERR = 8'h28;
  localparam logic [7:0] OFF_GEOM = 8'h2C;
  localparam logic [7:0] OFF_MODE = 8'h30;
  // Status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // Device control bit positions
  localparam int DC_SRST = 2;
  localparam int DC_NIEN = 1;
  // Drive/head field positions
  localparam int DH_DRV = 4;
  // Opcodes
  localparam logic [7:0] OP_RD = 8'h20;
  localparam logic [7:0] OP_RD_NR = 8'h21;
  localparam logic [7:0] OP_RDL = 8'h22;
  localparam logic [7:0] OP_RDL_NR = 8'h23;
  localparam logic [7:0] OP_WR = 8'h30;
  localparam logic [7:0] OP_WR_NR = 8'h31;
  localparam logic [7:0] OP_WRL = 8'h32;
  localparam logic [7:0] OP_WRL_NR = 8'h33;
  localparam logic [7:0] OP_WR_NE = 8'h38;
  localparam logic [7:0] OP_WR_VFY = 8'h3C;
  localparam logic [7:0] OP_VFY = 8'h40;
  localparam logic [7:0] OP_VFY_NR = 8'h41;
  localparam logic [7:0] OP_FMT = 8'h50;
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_INITP = 8'h91;
  localparam logic [7:0] OP_ERASE = 8'hC0;
  localparam logic [7:0] OP_RDM = 8'hC4;
  localparam logic [7:0] OP_WRM = 8'hC5;
  localparam logic [7:0] OP_SETM = 8'hC6;
  localparam logic [7:0] OP_WRM_NE = 8'hCD;
  localparam logic [7:0] OP_IDLE_I = 8'hE1;
  localparam logic [7:0] OP_IDLE_I2 = 8'h95;
  localparam logic [7:0] OP_IDLE = 8'hE3;
  localparam logic [7:0] OP_IDLE2 = 8'h97;
  localparam logic [7:0] OP_RDBUF = 8'hE4;
  localparam logic [7:0] OP_CHKPW = 8'hE5;
  localparam logic [7:0] OP_CHKPW2 = 8'h98;
  localparam logic [7:0] OP_SLEEP = 8'hE6;
  localparam logic [7:0] OP_SLEEP2 = 8'h99;
  localparam logic [7:0] OP_WRBUF = 8'hE8;
  localparam logic [7:0] OP_IDENT = 8'hEC;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;
  // Error codes and fill pattern
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] FILL_PAT = 8'hFF;
  // Power state codes reported in sector count
  localparam logic [7:0] PWR_IDLE = 8'hFF;
  localparam logic [7:0] PWR_SLEEP = 8'h00;
  // Identify words
  localparam logic [15:0] ID_W0 = 16'h044A;
  localparam logic [15:0] ID_W22 = 16'h0004;
  localparam logic [15:0] ID_W47 = 16'h0001;
  localparam logic [15:0] ID_W49 = 16'h0200;
  localparam logic [15:0] ID_W51 = 16'h0200;
  localparam logic [15:0] ID_W53 = 16'h0003;
  localparam logic [15:0] ID_W64 = 16'h0003;
  localparam logic [15:0] ID_W67 = 16'h0078;
  // Transfer sizes in 16-bit words
  localparam logic [8:0] WORDS_SECT = 9'd256;
  localparam logic [8:0] WORDS_LONG = 9'd258;
  // Recalibrate wait
  localparam int RECAL_US = 10;
  localparam int CLK_MHZ = 10;
  localparam logic [7:0] RECAL_CYC = 8'(RECAL_US * CLK_MHZ);
  // Busy wait before the first sector of a write command
  localparam logic [7:0] MEDIA_CYC = 8'd8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_XFER = 3'b011,
    ST_DONE = 3'b010,
    ST_SLEEP = 3'b110
  } acd_fsm_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } acd_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } acd_ahb_rsp_t;
endpackage

// ---- src/acd_core.sv ----
/*
 ATA command decoder core: task file over AHB-Lite, command execution,
 identify block and sector buffer streaming through the data register.
 Assumes one clock, an AHB-Lite master, and a media engine reached by
 the media request/done handshake.
*/
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Retry and no-retry opcode pairs run the same operation.
// - Diagnostic addressed to drive 0 runs self test, code in error register.
// - Sector read transfers sector count sectors, zero meaning 256.
// - Read multiple interrupts once per block of set-multiple size.
// - Long read delivers 516 bytes per sector.
// - Verify reads media, never sets data request, sends nothing.
// - Recalibrate holds busy a while, then interrupts; module initialized.
// - Idle sets power-down enable from nonzero sector count, interrupts.
// - Idle immediate enters idle at once, then interrupts.
// - Format accepts one sector, discards it, fills track with pattern.
// - Read buffer returns sector buffer without media access.
// - Identify word 0 is 044A.
// - Identify word 22 is 0004.
// - Identify word 47 is 0001.
// - Identify word 49 is 0200; DMA words read zero.
// - Identify word 53 is 0003.
// - Identify word 64 is 0003; words 67 and 68 are 0078.
// - Identify words 7 and 8 hold capacity, high half first.
// - Erase sectors conditions addressed sectors through the media engine.
// - Initialize parameters latches sectors per track and heads.
// - Check power mode reports power state in sector count.
// - Sector write accepts sector count sectors, zero meaning 256.
// - Sleep clears busy, interrupts, sleeps until a reset.
// - Status read clears interrupt; alternate status read does not.
module acd_core #(
  parameter logic [31:0] CAPACITY = 32'h0001_F400,
  parameter logic [15:0] CHIP_ID = 16'h5A5A // Arbitrary value
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire acd_pkg::acd_ahb_req_t ahb_req,
  input wire logic [31:0] hwdata,
  output acd_pkg::acd_ahb_rsp_t ahb_rsp,
  output logic host_interrupt_line,
  output logic media_req,
  output logic [7:0] media_op,
  output logic [7:0] media_sector,
  output logic [7:0] media_fill,
  input wire logic media_done
);
  import acd_pkg::*;

  typedef struct packed {
    logic aph;
    logic awr;
    logic [7:0] aoff;
    logic [31:0] rdata;
    logic [7:0] features_register;
    logic [7:0] sector_count_register;
    logic [7:0] sector_number_register;
    logic [15:0] cylinder_registers;
    logic drive_select_bit;
    logic [3:0] head_field;
    logic [7:0] cmd;
    logic [7:0] err;
    logic [7:0] devctl;
    acd_fsm_t fsm;
    logic busy_flag;
    logic data_request_flag;
    logic err_flag;
    logic irq;
    logic [8:0] left;
    logic [8:0] words;
    logic [7:0] blk;
    logic [7:0] wait_c;
    logic [7:0] spt;
    logic [3:0] heads;
    logic [7:0] mult;
    logic apd_en;
    logic sleeping;
    logic mreq;
    logic [7:0] widx;
    logic [255:0][15:0] buf_mem;
  } acd_st_t;

  acd_st_t s_q, s_d;

  function automatic logic [8:0] sect_cnt(input logic [7:0] sc);
    sect_cnt = (sc == 8'h00) ? 9'd256 : {1'b0, sc};
  endfunction

  function automatic logic [15:0] ident(input logic [7:0] w, input logic [31:0] cap,
                                        input logic [15:0] cid);
    case (w)
      8'd0: ident = ID_W0;
      8'd7: ident = cap[31:16];
      8'd8: ident = cap[15:0];
      8'd10: ident = cid;
      8'd22: ident = ID_W22;
      8'd47: ident = ID_W47;
      8'd49: ident = ID_W49;
      8'd51: ident = ID_W51;
      8'd53: ident = ID_W53;
      8'd64: ident = ID_W64;
      8'd67: ident = ID_W67;
      8'd68: ident = ID_W67;
      default: ident = 16'h0000;
    endcase
  endfunction

  logic [15:0] rd_word;
  logic take_ap, dph_wr, dph_rd;
  always_comb begin
    rd_word = (s_q.cmd == OP_IDENT) ? ident(s_q.widx, CAPACITY, CHIP_ID)
                                   : s_q.buf_mem[s_q.widx];
    take_ap = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
    dph_wr = s_q.aph & s_q.awr;
    dph_rd = s_q.aph & ~s_q.awr;
  end

  always_comb begin
    logic [7:0] op, st;
    logic mult_rd, xfer_out;
    op = hwdata[7:0];
    s_d = s_q;
    st = {s_q.busy_flag, ~s_q.busy_flag, 1'b0, ~s_q.busy_flag,
          s_q.data_request_flag, 2'b00, s_q.err_flag};
    mult_rd = (s_q.cmd == OP_RDM);
    xfer_out = (s_q.cmd == OP_IDENT) || (s_q.cmd == OP_RDBUF) ||
               (s_q.cmd[7:4] == 4'h2) || mult_rd;
    if (clk_en) begin
      s_d.aph = take_ap;
      s_d.awr = ahb_req.hwrite;
      s_d.aoff = ahb_req.haddr[7:0];
      // Read data registered at the address phase for a zero-wait answer
      if (take_ap && !ahb_req.hwrite) begin
        if (ahb_req.haddr[7:0] == OFF_STAT || ahb_req.haddr[7:0] == OFF_ALTST) begin
          s_d.rdata = {24'h0, st};
        end else if (ahb_req.haddr[7:0] == OFF_SCNT) begin
          s_d.rdata = {24'h0, s_q.sector_count_register};
        end else if (ahb_req.haddr[7:0] == OFF_SNUM) begin
          s_d.rdata = {24'h0, s_q.sector_number_register};
        end else if (ahb_req.haddr[7:0] == OFF_CYL) begin
          s_d.rdata = {16'h0, s_q.cylinder_registers};
        end else if (ahb_req.haddr[7:0] == OFF_DRVHD) begin
          s_d.rdata = {24'h0, 3'b101, s_q.drive_select_bit, s_q.head_field};
        end else if (ahb_req.haddr[7:0] == OFF_ERR) begin
          s_d.rdata = {24'h0, s_q.err};
        end else if (ahb_req.haddr[7:0] == OFF_DATA) begin
          s_d.rdata = {16'h0, rd_word};
        end else if (ahb_req.haddr[7:0] == OFF_GEOM) begin
          s_d.rdata = {20'h0, s_q.heads, s_q.spt};
        end else if (ahb_req.haddr[7:0] == OFF_MODE) begin
          s_d.rdata = {22'h0, s_q.sleeping, s_q.apd_en, s_q.mult};
        end else begin
          s_d.rdata = 32'h0;
        end
        if (ahb_req.haddr[7:0] == OFF_STAT) begin
          s_d.irq = 1'b0;
        end
      end
      s_d.mreq = 1'b0;
      // Task file writes ignored while busy, except device control
      if (dph_wr && !s_q.busy_flag) begin
        if (s_q.aoff == OFF_FEAT) s_d.features_register = hwdata[7:0];
        else if (s_q.aoff == OFF_SCNT) s_d.sector_count_register = hwdata[7:0];
        else if (s_q.aoff == OFF_SNUM) s_d.sector_number_register = hwdata[7:0];
        else if (s_q.aoff == OFF_CYL) s_d.cylinder_registers = hwdata[15:0];
        else if (s_q.aoff == OFF_DRVHD) begin
          s_d.drive_select_bit = hwdata[DH_DRV];
          s_d.head_field = hwdata[3:0];
        end
      end
      if (dph_wr && s_q.aoff == OFF_DEVCTL) s_d.devctl = hwdata[7:0];
      case (s_q.fsm)
        ST_IDLE: begin
          if (dph_wr && s_q.aoff == OFF_CMD) begin
            s_d.cmd = op;
            s_d.err_flag = 1'b0;
            s_d.err = 8'h00;
            s_d.busy_flag = 1'b1;
            s_d.irq = 1'b0;
            s_d.fsm = ST_BUSY;
            s_d.widx = 8'h00;
            s_d.words = WORDS_SECT;
            s_d.blk = 8'h01;
            s_d.wait_c = MEDIA_CYC;
            s_d.left = sect_cnt(s_q.sector_count_register);
            if (op == OP_RD || op == OP_RD_NR || op == OP_RDM || op == OP_WR ||
                op == OP_WR_NR || op == OP_WR_NE || op == OP_WR_VFY ||
                op == OP_WRM || op == OP_WRM_NE || op == OP_VFY ||
                op == OP_VFY_NR || op == OP_ERASE) begin
              s_d.mreq = (op[7:4] != 4'h3) && (op != OP_WRM) && (op != OP_WRM_NE);
            end else if (op == OP_RDL || op == OP_RDL_NR || op == OP_WRL ||
                         op == OP_WRL_NR) begin
              s_d.words = WORDS_LONG;
              s_d.left = 9'd1;
              s_d.mreq = (op[7:4] == 4'h2);
            end else if (op == OP_IDENT || op == OP_RDBUF) begin
              s_d.left = 9'd1;
              s_d.wait_c = 8'd1;
            end else if (op == OP_WRBUF || op == OP_FMT) begin
              s_d.left = 9'd1;
              s_d.wait_c = 8'd1;
            end else if (op[7:4] == OP_RECAL_HI) begin
              s_d.wait_c = RECAL_CYC;
            end else if (op == OP_DIAG || op == OP_INITP || op == OP_SETM ||
                         op == OP_IDLE || op == OP_IDLE2 || op == OP_IDLE_I ||
                         op == OP_IDLE_I2 || op == OP_CHKPW || op == OP_CHKPW2 ||
                         op == OP_SLEEP || op == OP_SLEEP2) begin
              s_d.wait_c = 8'd1;
            end else begin
              s_d.err_flag = 1'b1;
              s_d.err = ERR_ABORT;
              s_d.fsm = ST_DONE;
            end
          end
        end
        ST_BUSY: begin
          if (s_q.cmd[7:4] == 4'h2 || s_q.cmd[7:4] == 4'h4 || s_q.cmd == OP_RDM ||
              s_q.cmd == OP_ERASE || (s_q.cmd == OP_FMT && s_q.left == 9'd0)) begin
            if (media_done) begin
              if (s_q.cmd[7:4] == 4'h4 || s_q.cmd == OP_ERASE || s_q.cmd == OP_FMT) begin
                s_d.left = s_q.left - 9'd1;
                s_d.sector_number_register = s_q.sector_number_register + 8'd1;
                if (s_q.left <= 9'd1) s_d.fsm = ST_DONE;
                else s_d.mreq = 1'b1;
              end else begin
                s_d.busy_flag = 1'b0;
                s_d.data_request_flag = 1'b1;
                s_d.widx = 8'h00;
                s_d.irq = !mult_rd || (s_q.blk == 8'h01);
                s_d.fsm = ST_XFER;
              end
            end
          end else if (s_q.wait_c > 8'd1) begin
            s_d.wait_c = s_q.wait_c - 8'd1;
          end else if (xfer_out || s_q.cmd[7:4] == 4'h3 || s_q.cmd == OP_WRM ||
                       s_q.cmd == OP_WRM_NE || s_q.cmd == OP_WRBUF || s_q.cmd == OP_FMT) begin
            s_d.busy_flag = 1'b0;
            s_d.data_request_flag = 1'b1;
            s_d.irq = xfer_out;
            s_d.fsm = ST_XFER;
          end else begin
            if (s_q.cmd == OP_DIAG) s_d.err = DIAG_OK;
            if (s_q.cmd == OP_INITP) begin
              s_d.spt = s_q.sector_count_register;
              s_d.heads = s_q.head_field;
            end
            if (s_q.cmd == OP_SETM) s_d.mult = s_q.sector_count_register;
            if (s_q.cmd == OP_IDLE || s_q.cmd == OP_IDLE2) begin
              s_d.apd_en = (s_q.sector_count_register != 8'h00);
            end
            if (s_q.cmd == OP_CHKPW || s_q.cmd == OP_CHKPW2) begin
              s_d.sector_count_register = PWR_IDLE;
            end
            s_d.fsm = ST_DONE;
          end
        end
        ST_XFER: begin
          if (s_q.aph && s_q.aoff == OFF_DATA && (s_q.awr != xfer_out)) begin
            if (s_q.awr && s_q.cmd == OP_WRBUF) s_d.buf_mem[s_q.widx] = hwdata[15:0];
            s_d.widx = s_q.widx + 8'd1;
            s_d.words = s_q.words - 9'd1;
            if (s_q.words == 9'd1) begin
              s_d.data_request_flag = 1'b0;
              s_d.left = s_q.left - 9'd1;
              s_d.sector_number_register = s_q.sector_number_register + 8'd1;
              s_d.blk = (s_q.blk >= s_q.mult) ? 8'h01 : s_q.blk + 8'd1;
              s_d.words = (s_q.cmd[7:4] != 4'h2 && s_q.cmd[7:4] != 4'h3) ||
                          s_q.cmd[1] == 1'b0 ? WORDS_SECT : WORDS_LONG;
              if (s_q.cmd == OP_FMT) s_d.mreq = 1'b1;
              if (s_q.left == 9'd1 && !xfer_out && s_q.cmd != OP_FMT) begin
                s_d.fsm = ST_DONE;
              end else if (s_q.left == 9'd1 && xfer_out) begin
                s_d.fsm = ST_IDLE;
              end else begin
                s_d.busy_flag = 1'b1;
                s_d.mreq = s_q.cmd[7:4] != 4'h3 && s_q.cmd != OP_WRM &&
                           s_q.cmd != OP_WRM_NE || s_q.cmd == OP_FMT;
                s_d.wait_c = 8'd1;
                s_d.fsm = ST_BUSY;
              end
            end
          end
        end
        ST_DONE: begin
          s_d.busy_flag = 1'b0;
          s_d.irq = 1'b1;
          s_d.fsm = ST_IDLE;
          if (s_q.cmd == OP_SLEEP || s_q.cmd == OP_SLEEP2) begin
            s_d.sleeping = 1'b1;
            s_d.fsm = ST_SLEEP;
          end
        end
        default: begin
          s_d.fsm = ST_SLEEP;
        end
      endcase
      // Soft reset overrides the state, busy, data request and interrupt, including sleep
      if (s_q.devctl[DC_SRST]) begin
        s_d.fsm = ST_IDLE;
        s_d.busy_flag = 1'b0;
        s_d.data_request_flag = 1'b0;
        s_d.irq = 1'b0;
        s_d.sleeping = 1'b0;
        s_d.err = DIAG_OK;
        s_d.devctl[DC_SRST] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.sector_count_register <= 8'h01;
      s_q.sector_number_register <= 8'h01;
      s_q.mult <= 8'h01;
      s_q.err <= DIAG_OK;
      s_q.fsm <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    ahb_rsp.hrdata = s_q.rdata;
    ahb_rsp.hreadyout = clk_en; // Wait states while frozen
    ahb_rsp.hresp = 1'b0;
    host_interrupt_line = s_q.irq & ~s_q.devctl[DC_NIEN];
    media_req = s_q.mreq;
    media_op = s_q.cmd;
    media_sector = s_q.sector_number_register;
    media_fill = FILL_PAT;
  end

  chk_verify_no_drq: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.cmd == OP_VFY || s_q.cmd == OP_VFY_NR) && s_q.fsm != ST_IDLE |->
    !s_q.data_request_flag) else $error("verify raised data request");
  chk_stat_clears_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && take_ap && !ahb_req.hwrite && ahb_req.haddr[7:0] == OFF_STAT &&
    s_q.fsm == ST_IDLE |=> !s_q.irq) else $error("status read kept irq");
  chk_bad_op_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && s_q.fsm == ST_IDLE && dph_wr && s_q.aoff == OFF_CMD && hwdata[7:0] == 8'h87
    |=> s_q.err_flag && s_q.fsm == ST_DONE ##1 s_q.irq && !s_q.busy_flag)
    else $error("unsupported opcode not aborted");
  chk_recal_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_q.busy_flag) && s_q.cmd[7:4] == OP_RECAL_HI |=> s_q.busy_flag[*8])
    else $error("recalibrate dropped busy early");
  chk_idle_apd: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && s_q.fsm == ST_BUSY && s_q.cmd == OP_IDLE && s_q.wait_c == 8'd1 |=>
    s_q.apd_en == (s_q.sector_count_register != 8'h00)) else $error("apd wrong");
  chk_id_word0: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.cmd == OP_IDENT && s_q.widx == 8'h00 |-> rd_word == ID_W0)
    else $error("identify word 0 wrong");
  chk_id_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.cmd == OP_IDENT && s_q.widx == 8'd7 |-> rd_word == CAPACITY[31:16])
    else $error("identify capacity wrong");
  chk_sleep_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.fsm == ST_SLEEP && !s_q.devctl[DC_SRST] |=> s_q.fsm == ST_SLEEP)
    else $error("left sleep without reset");
  chk_count_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && s_q.fsm == ST_IDLE && dph_wr && s_q.aoff == OFF_CMD &&
    (hwdata[7:0] == OP_RD || hwdata[7:0] == OP_VFY_NR) &&
    s_q.sector_count_register == 8'h00 |=> s_q.left == 9'd256) else $error("count 0");
  cov_identify: cover property (@(posedge hclk) s_q.cmd == OP_IDENT && s_q.words == 9'd1);
  cov_sleep: cover property (@(posedge hclk) s_q.fsm == ST_SLEEP);
  cov_abort: cover property (@(posedge hclk) s_q.err == ERR_ABORT);
endmodule
`default_nettype wire

// ---- test/acd_media_model.sv ----
/*
 Media engine model: one media_done pulse for each media_req, after a
 random delay. Assumes the decoder's clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none
module acd_media_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic media_req,
  input wire logic [7:0] media_sector,
  input wire logic [7:0] media_fill,
  output logic media_done,
  output int n_req,
  output logic [7:0] last_sec,
  output logic [7:0] last_fill
);
  int wait_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      media_done <= 1'b0;
      n_req <= 0;
      wait_q <= -1;
      last_sec <= 8'h00;
      last_fill <= 8'h00;
    end else begin
      media_done <= 1'b0;
      if (media_req) begin
        n_req <= n_req + 1;
        last_sec <= media_sector;
        last_fill <= media_fill;
        // Prompt and slow answers alike
        wait_q <= int'($urandom_range(12, 0));
      end else if (wait_q == 0) begin
        media_done <= 1'b1;
        wait_q <= -1;
      end else if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
/*
 Self-checking bench for acd_core: AHB-Lite master tasks, media model,
 random task-file values from a fixed seed. Assumes one 10 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import acd_pkg::*;
  localparam logic [31:0] CAP = 32'h0003_2100;
  logic hclk, hresetn, hwrite, hsel, irq, mreq, mdone, clk_en;
  bit wr_k, gate;
  logic [31:0] haddr, hwdata, rdv;
  logic [1:0] htrans;
  logic [7:0] mop, msec, mfill, lsec, lfill, sn, sc, op;
  logic [3:0] hd;
  logic [15:0] dbuf [0:511];
  logic [15:0] wbuf [0:255];
  acd_ahb_req_t req;
  acd_ahb_rsp_t rsp;
  int n_req, bad_count, n_checks, nw, r0;
  int idw[18] = '{0, 7, 8, 22, 47, 48, 49, 52, 53, 62, 63, 64, 65, 66, 67, 68, 69, 255};
  logic [7:0] xop[15] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'hC4, 8'h40, 8'h41, 8'h30, 8'h31,
    8'h32, 8'h38, 8'h3C, 8'hC5, 8'hCD, 8'hC0};
  int xsc[15] = '{2, 1, 1, 1, 2, 3, 0, 2, 1, 1, 1, 1, 1, 1, 2};
  logic [7:0] nop[9] = '{8'hC6, 8'h91, 8'h90, 8'hE1, 8'h95, 8'hE3, 8'h97, 8'hE5, 8'h98};
  assign req = {haddr, htrans, hwrite, 3'b010, hsel, rsp.hreadyout};
  // Frozen cycles only where no media handshake is in flight
  always @(posedge hclk) clk_en <= gate ? ($urandom_range(3, 0) != 0) : 1'b1;
  acd_core #(.CAPACITY(CAP)) acd_core_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .ahb_req(req), .hwdata(hwdata), .ahb_rsp(rsp), .host_interrupt_line(irq),
    .media_req(mreq), .media_op(mop), .media_sector(msec), .media_fill(mfill),
    .media_done(mdone));
  acd_media_model acd_media_model_i (.hclk(hclk), .hresetn(hresetn), .media_req(mreq),
    .media_sector(msec), .media_fill(mfill), .media_done(mdone), .n_req(n_req),
    .last_sec(lsec), .last_fill(lfill));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task finish_test;
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tmo;
    bad_count++;
    finish_test;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] id_exp(input int w);
    case (w)
      0: return 16'h044A;
      7: return CAP[31:16];
      8: return CAP[15:0];
      22: return 16'h0004;
      47: return 16'h0001;
      49: return 16'h0200;
      53, 64: return 16'h0003;
      67, 68: return 16'h0078;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic int wps(input logic [7:0] o);
    if (o[7:4] == 4'h4 || o == OP_ERASE)
      return 0;
    return (o[7:1] == 7'h11 || o[7:1] == 7'h19) ? 258 : 256;
  endfunction
  task automatic edge_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (rsp.hreadyout !== 1'b1) begin
      i++;
      if (i > 50) tmo;
      @(posedge hclk);
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    edge_rdy;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    edge_rdy;
    rdv = rsp.hrdata;
  endtask
  task automatic wnb;
    int i;
    i = 0;
    do begin
      bus(1'b0, OFF_ALTST, 32'h0);
      i++;
      if (i > 6000) tmo;
    end while (rdv[ST_BSY] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] o, input logic [7:0] c, input bit ld);
    r0 = n_req;
    // Only what the command needs, sector and head kept in range
    if (ld) bus(1'b1, OFF_SCNT, {24'h0, c});
    if (ld) bus(1'b1, OFF_SNUM, {24'h0, sn});
    bus(1'b1, OFF_DRVHD, {28'h0, hd});
    bus(1'b1, OFF_CMD, {24'h0, o});
  endtask
  // Missing words would leave the data request standing at the end
  task automatic xfer(input bit wr, input int n);
    int i;
    i = 0;
    nw = 0;
    while (nw < n) begin
      bus(1'b0, OFF_ALTST, 32'h0);
      i++;
      if (i > 9000) tmo;
      if (rdv[ST_BSY] === 1'b0 && rdv[ST_DRQ] === 1'b1) begin
        bus(wr, OFF_DATA, {16'h0, dbuf[nw]});
        if (!wr) dbuf[nw] = rdv[15:0];
        nw++;
      end
    end
    wnb;
    chk(rdv[ST_DRQ], 1'b0);
  endtask
  task automatic irq_seen;
    repeat (2) @(posedge hclk);
    chk(irq, 1'b1);
  endtask
  initial begin
    hresetn = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsel = 1'b0;
    hd = 4'h0;
    sn = 8'h01;
    r0 = $urandom(36);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h40, 32'h0);
    chk(rdv, 32'h0);
    gate <= 1'b1;
    cmd(OP_IDENT, 8'h00, 1'b0);
    xfer(1'b0, 256);
    foreach (idw[k]) chk(dbuf[idw[k]], id_exp(idw[k]));
    chk(irq, 1'b1);
    bus(1'b0, OFF_STAT, 32'h0);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    foreach (wbuf[k]) begin
      wbuf[k] = 16'($urandom);
      dbuf[k] = wbuf[k];
    end
    cmd(OP_WRBUF, 8'h00, 1'b0);
    xfer(1'b1, 256);
    cmd(OP_RDBUF, 8'h00, 1'b0);
    xfer(1'b0, 256);
    foreach (wbuf[k]) chk(dbuf[k], wbuf[k]);
    chk(n_req - r0, 0);
    gate <= 1'b0;
    foreach (nop[k]) begin
      sc = (nop[k] == OP_SETM) ? 8'h01 : 8'($urandom_range(3, 0));
      hd = 4'($urandom_range(3, 0));
      op = nop[k];
      cmd(op, sc, !(op inside {OP_DIAG, OP_IDLE_I, OP_IDLE_I2}));
      wnb;
      irq_seen;
      chk(rdv[ST_ERR], 1'b0);
      bus(1'b0, (op == OP_DIAG) ? OFF_ERR : (op == OP_INITP) ? OFF_GEOM :
        (op inside {OP_CHKPW, OP_CHKPW2}) ? OFF_SCNT : OFF_MODE, 32'h0);
      if (op == OP_DIAG) chk(rdv[7:0], 8'h01);
      if (op == OP_INITP) chk(rdv[11:0], {hd, sc});
      if (op == OP_SETM) chk(rdv[7:0], sc);
      if (op inside {OP_IDLE, OP_IDLE2}) chk(rdv[8], sc != 8'h00);
      if (op inside {OP_CHKPW, OP_CHKPW2}) chk(rdv[7:0], PWR_IDLE);
    end
    foreach (xop[k]) begin
      sn = 8'($urandom_range(32, 1));
      hd = 4'($urandom_range(3, 0));
      sc = 8'(xsc[k]);
      cmd(xop[k], sc, 1'b1);
      wr_k = xop[k][4] | xop[k][0] & xop[k][7];
      xfer(wr_k, (sc == 0 ? 256 : int'(sc)) * wps(xop[k]));
      chk(n_req - r0, wr_k ? 0 : (sc == 0 ? 256 : int'(sc)));
      chk(mop, xop[k]);
      if (sc == 8'h01 && xop[k][7:4] == 4'h2) chk(lsec, sn);
    end
    cmd(OP_FMT, 8'h01, 1'b1);
    xfer(1'b1, 256);
    chk(n_req - r0, 1);
    chk(lfill, 8'hFF);
    cmd(8'h87, 8'h01, 1'b1);
    wnb;
    chk(rdv[ST_ERR], 1'b1);
    bus(1'b0, OFF_ERR, 32'h0);
    chk(rdv[7:0], ERR_ABORT);
    chk(n_req - r0, 0);
    cmd({4'h1, 4'($urandom)}, 8'h00, 1'b0);
    repeat (60) @(posedge hclk);
    bus(1'b0, OFF_ALTST, 32'h0);
    chk(rdv[ST_BSY], 1'b1);
    wnb;
    irq_seen;
    for (int k = 0; k < 2; k++) begin
      cmd(k == 0 ? OP_SLEEP : OP_SLEEP2, 8'h00, 1'b0);
      wnb;
      irq_seen;
      bus(1'b0, OFF_MODE, 32'h0);
      chk(rdv[9], 1'b1);
      bus(1'b1, OFF_DEVCTL, 32'h0000_000C);
      repeat (4) @(posedge hclk);
      bus(1'b0, OFF_MODE, 32'h0);
      chk(rdv[9], 1'b0);
    end
    finish_test;
  end
endmodule
`default_nettype wire
